// ==== common/rmx_pkg.sv ====
`default_nettype none
package rmx_pkg;
    localparam int unsigned NUM_REQ = 4;
    localparam int unsigned MODE_W = 4;
    localparam int unsigned SYNC_STAGES = 2;
    // Operating mode held until the mode is latched at reset release.
    localparam logic [3:0] MODE_RST = 4'h0;
    // Per-request configuration after reset: all masked, level-sensitive.
    localparam logic [3:0] MASK_RST = 4'hf;
    localparam logic [3:0] EDGE_RST = 4'h0;
    // Core output clock phase divider: one enable every PHASE_DIV core cycles.
    localparam logic [1:0] PHASE_DIV = 2'h2;
    // Index of the request that may also end the Stop state.
    localparam int unsigned STOP_REQ = 0;

    typedef enum logic [2:0] {
        RMX_RESET = 3'b001,
        RMX_LATCH = 3'b010,
        RMX_RUN = 3'b100
    } rmx_state_t;
endpackage : rmx_pkg
`default_nettype wire

// ==== common/rmx_sync_if.sv ====
`timescale 1ns/100ps
`default_nettype none
// Carries the synchronised request pins from the synchroniser to the core.
interface rmx_sync_if;
    logic [3:0] pins_n;
    modport src (output pins_n);
    modport dst (input pins_n);
endinterface : rmx_sync_if
`default_nettype wire

// ==== rtl/rmx_sync.sv ====
`timescale 1ns/100ps
`default_nettype none
// Two-stage synchroniser for the shared mode/request pins.
module rmx_sync (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [3:0] pins_n_i,
    rmx_sync_if.src sync
);
    logic [3:0] meta;
    logic [3:0] stable;
    logic [3:0] next_meta;
    logic [3:0] next_stable;

    always_comb begin
        next_meta = pins_n_i;
        next_stable = meta;
    end

    // Pins idle high, so reset to the inactive level.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta <= 4'hf;
            stable <= 4'hf;
        end else begin
            meta <= next_meta;
            stable <= next_stable;
        end
    end

    assign sync.pins_n = stable;
endmodule // rmx_sync
`default_nettype wire

// ==== rtl/rmx_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module rmx_top (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic [3:0] mode_int_n_i,
    input wire logic [3:0] int_mask_i,
    input wire logic [3:0] int_edge_sel_i,
    input wire logic wait_state_i,
    input wire logic stop_state_i,
    output logic chip_reset_n_o,
    output logic core_clock_output_o,
    output logic [3:0] operating_mode_reg_o,
    output logic [3:0] ext_int_pending_o,
    output logic wake_o
);
    ////////////////////////////////////////////////////////////////////////
    logic rst_meta;
    logic rst_sync;

    // The Schmitt stage is analogue; digitally the low level is taken as reset.
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Phase generator: reset with the chip so every device starts in phase.
    logic [1:0] phase;
    logic clk_out;
    logic [1:0] next_phase;
    logic next_clk_out;
    logic phase_en;

    always_comb begin
        phase_en = (phase == rmx_pkg::PHASE_DIV - 2'h1);
        next_phase = phase_en ? 2'h0 : phase + 2'h1;
        next_clk_out = phase_en ? ~clk_out : clk_out;
    end

    always_ff @(posedge core_clk_i or negedge rst_sync) begin
        if (!rst_sync) begin
            phase <= 2'h0;
            clk_out <= 1'b0;
        end else begin
            phase <= next_phase;
            clk_out <= next_clk_out;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    rmx_sync_if sync_bus ();

    rmx_sync u_sync (
        .clk_i(core_clk_i),
        .rst_n_i(rst_sync),
        .pins_n_i(mode_int_n_i),
        .sync(sync_bus.src)
    );

    // Mode pins are sampled raw (two stages) while reset, so a separate
    // always-running synchroniser keeps the last value seen before release.
    logic [3:0] mode_meta;
    logic [3:0] mode_seen;

    always_ff @(posedge core_clk_i) begin
        mode_meta <= mode_int_n_i;
        mode_seen <= mode_meta;
    end

    ////////////////////////////////////////////////////////////////////////
    rmx_pkg::rmx_state_t state;
    rmx_pkg::rmx_state_t next_state;
    logic [3:0] mode;
    logic [3:0] next_mode;
    logic [3:0] mask;
    logic [3:0] edge_sel;
    logic [3:0] next_mask;
    logic [3:0] next_edge_sel;
    logic [3:0] prev_n;
    logic [3:0] next_prev_n;
    logic [3:0] pend;
    logic [3:0] next_pend;
    logic wake;
    logic next_wake;
    logic chip_rst_n;
    logic next_chip_rst_n;
    logic [3:0] fall;
    logic [3:0] req;

    always_comb begin
        next_state = state;
        next_mode = mode;
        next_mask = mask;
        next_edge_sel = edge_sel;
        next_prev_n = sync_bus.pins_n;
        next_pend = pend;
        next_wake = 1'b0;
        next_chip_rst_n = chip_rst_n;
        fall = prev_n & ~sync_bus.pins_n;
        req = 4'h0;
        case (state)
            rmx_pkg::RMX_RESET: begin
                next_state = rmx_pkg::RMX_LATCH;
            end
            rmx_pkg::RMX_LATCH: begin
                next_mode = mode_seen;
                next_chip_rst_n = 1'b1;
                next_state = rmx_pkg::RMX_RUN;
            end
            rmx_pkg::RMX_RUN: begin
                next_mask = int_mask_i;
                next_edge_sel = int_edge_sel_i;
                for (int i = 0; i < 4; i++) begin
                    req[i] = edge_sel[i] ? fall[i] : ~sync_bus.pins_n[i];
                end
                req = req & ~mask;
                // Edge requests stay pending until the edge mode is left or the request is masked;
                // level requests follow the pin.
                next_pend = (pend & edge_sel & ~mask) | req;
                next_wake = (wait_state_i && (req != 4'h0))
                    || (stop_state_i && req[rmx_pkg::STOP_REQ]);
            end
            default: begin
                next_state = rmx_pkg::RMX_RESET;
            end
        endcase
    end

    // Until RUN the pins feed the mode path and the prev_n edge history, never a request.
    always_ff @(posedge core_clk_i or negedge rst_sync) begin
        if (!rst_sync) begin
            state <= rmx_pkg::RMX_RESET;
            mode <= rmx_pkg::MODE_RST;
            mask <= rmx_pkg::MASK_RST;
            edge_sel <= rmx_pkg::EDGE_RST;
            prev_n <= 4'hf;
            pend <= 4'h0;
            wake <= 1'b0;
            chip_rst_n <= 1'b0;
        end else begin
            state <= next_state;
            mode <= next_mode;
            mask <= next_mask;
            edge_sel <= next_edge_sel;
            prev_n <= next_prev_n;
            pend <= next_pend;
            wake <= next_wake;
            chip_rst_n <= next_chip_rst_n;
        end
    end

    assign chip_reset_n_o = chip_rst_n;
    assign core_clock_output_o = clk_out;
    assign operating_mode_reg_o = mode;
    assign ext_int_pending_o = pend;
    assign wake_o = wake;

    ////////////////////////////////////////////////////////////////////////
    sequence s_released;
        state == rmx_pkg::RMX_LATCH;
    endsequence

    property p_mode_latch;
        @(posedge core_clk_i) disable iff (!rst_sync)
        s_released |=> (operating_mode_reg_o == $past(mode_seen));
    endproperty
    a_mode_latch: assert property (p_mode_latch) else $error("mode not latched");

    property p_mode_hold;
        @(posedge core_clk_i) disable iff (!rst_sync)
        (state == rmx_pkg::RMX_RUN) |=> $stable(operating_mode_reg_o);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("mode changed in run");

    property p_no_req_in_reset;
        @(posedge core_clk_i) disable iff (!rst_sync)
        (state != rmx_pkg::RMX_RUN) |-> (pend == 4'h0 && !wake);
    endproperty
    a_no_req_in_reset: assert property (p_no_req_in_reset) else $error("request in reset");

    property p_chip_release;
        @(posedge core_clk_i) disable iff (!rst_sync)
        $rose(chip_reset_n_o) |-> $past(state == rmx_pkg::RMX_LATCH);
    endproperty
    a_chip_release: assert property (p_chip_release) else $error("early release");

    // The pending flags are built from the mask held one cycle earlier.
    property p_masked;
        @(posedge core_clk_i) disable iff (!rst_sync)
        (state == rmx_pkg::RMX_RUN) |-> ((ext_int_pending_o & $past(mask)) == 4'h0);
    endproperty
    a_masked: assert property (p_masked) else $error("masked request pending");

    property p_wait_wake;
        @(posedge core_clk_i) disable iff (!rst_sync)
        (state == rmx_pkg::RMX_RUN && wait_state_i && (req != 4'h0)) |=> wake_o;
    endproperty
    a_wait_wake: assert property (p_wait_wake) else $error("wait not left");

    property p_stop_wake;
        @(posedge core_clk_i) disable iff (!rst_sync)
        (state == rmx_pkg::RMX_RUN && stop_state_i && req[rmx_pkg::STOP_REQ]) |=> wake_o;
    endproperty
    a_stop_wake: assert property (p_stop_wake) else $error("stop not left");

    property p_clk_toggle;
        @(posedge core_clk_i) disable iff (!rst_sync)
        phase_en |=> (core_clock_output_o != $past(core_clock_output_o));
    endproperty
    a_clk_toggle: assert property (p_clk_toggle) else $error("clock out stuck");

    property p_mask_reset;
        @(posedge core_clk_i) disable iff (!rst_sync)
        (state == rmx_pkg::RMX_LATCH) |-> (mask == rmx_pkg::MASK_RST);
    endproperty
    a_mask_reset: assert property (p_mask_reset) else $error("mask not reset");
endmodule // rmx_top
`default_nettype wire

// ==== testbench/rmx_board_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// Board logic: reset and the shared pins change only just after a core clock edge.
module rmx_board_model (
    input wire logic clk_i,
    input wire logic rst_req_n_i,
    input wire logic [3:0] pins_req_n_i,
    output logic resetn_o,
    output logic [3:0] pins_n_o
);
    initial begin
        resetn_o = 1'b0;
        pins_n_o = 4'hf;
    end
    // Clock-aligned edges give every device on the board the same start-up and wake cycle.
    always @(posedge clk_i) begin
        resetn_o <= rst_req_n_i;
        pins_n_o <= pins_req_n_i;
    end
endmodule // rmx_board_model
`default_nettype wire

// ==== testbench/tb_reset_mode_latch_ext_irq.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_reset_mode_latch_ext_irq;
    logic clk = 1'b0;
    logic rst_req_n = 1'b0;
    logic [3:0] pins_req_n = 4'hf;
    logic [3:0] mask = 4'hf;
    logic [3:0] edge_sel = 4'h0;
    logic wait_st = 1'b0;
    logic stop_st = 1'b0;
    logic resetn, chip_rst_n, clk_out, clk_out_q, wake;
    logic [3:0] pins_n, mode, pend;
    int fail_count = 0;
    int checks_done = 0;
    int cycles = 0;
    int wake_cnt = 0;
    int toggles = 0;
    // Columns: mask, edge select, pin levels, expected pending.
    localparam logic [15:0] ROWS [8] = '{16'h00f0, 16'h00a5, 16'h500a, 16'hfff0,
                                         16'h0ff0, 16'h0f69, 16'h0ff9, 16'hfff0};
////////////////////////////////////////////////////////////////////////////////
    always #5 clk = ~clk;
    rmx_board_model rmx_board_model_inst (.clk_i(clk), .rst_req_n_i(rst_req_n),
        .pins_req_n_i(pins_req_n), .resetn_o(resetn), .pins_n_o(pins_n));
    rmx_top rmx_top_inst (.core_clk_i(clk), .resetn_i(resetn), .mode_int_n_i(pins_n),
        .int_mask_i(mask), .int_edge_sel_i(edge_sel), .wait_state_i(wait_st),
        .stop_state_i(stop_st), .chip_reset_n_o(chip_rst_n),
        .core_clock_output_o(clk_out), .operating_mode_reg_o(mode),
        .ext_int_pending_o(pend), .wake_o(wake));
////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [3:0] seen, input logic [3:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Pins sit at the mode code through reset, so they must not show up as requests.
    task automatic do_reset(input logic [3:0] m);
        @(posedge clk);
        rst_req_n <= 1'b0;
        pins_req_n <= m;
        repeat (12) @(negedge clk);
        check({3'h0, chip_rst_n}, 4'h0);
        check({3'h0, clk_out}, 4'h0);
        check(mode, rmx_pkg::MODE_RST);
        check(pend, 4'h0);
        @(posedge clk);
        rst_req_n <= 1'b1;
        for (int i = 0; i < 12 && chip_rst_n !== 1'b1; i++) @(negedge clk);
        check({3'h0, chip_rst_n}, 4'h1);
        check(mode, m);
        @(posedge clk);
        pins_req_n <= 4'hf;
        repeat (8) @(negedge clk);
        check(mode, m);
    endtask
    task automatic wake_step(input logic [3:0] p, input logic [3:0] exp);
        @(negedge clk) wake_cnt = 0;
        @(posedge clk);
        pins_req_n <= p;
        repeat (8) @(negedge clk);
        check(4'(wake_cnt), exp);
    endtask
////////////////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        cycles++;
        if (wake === 1'b1) wake_cnt++;
        if (clk_out !== clk_out_q) toggles++;
        clk_out_q <= clk_out;
        if (cycles == 3000) begin
            fail_count++;
            tally_and_finish();
        end
    end
    initial begin
        do_reset(4'h0);
        @(negedge clk) toggles = 0;
        repeat (8) @(negedge clk);
        check(4'(toggles), 4'h4);
        foreach (ROWS[r]) begin
            @(posedge clk);
            mask <= ROWS[r][15:12];
            edge_sel <= ROWS[r][11:8];
            pins_req_n <= ROWS[r][7:4];
            repeat (8) @(negedge clk);
            check(pend, ROWS[r][3:0]);
        end
        @(posedge clk);
        mask <= 4'h0;
        wait_st <= 1'b1;
        wake_step(4'he, 4'h1);
        @(posedge clk);
        mask <= 4'hf;
        wait_st <= 1'b0;
        stop_st <= 1'b1;
        wake_step(4'hf, 4'h0);
        @(posedge clk);
        mask <= 4'h0;
        wake_step(4'hd, 4'h0);
        wake_step(4'hc, 4'h1);
        @(posedge clk);
        mask <= 4'hf;
        stop_st <= 1'b0;
        wait_st <= 1'b1;
        wake_step(4'h0, 4'h0);
        // Resets in mid-run, each latching a different mode code.
        for (int k = 5; k < 16; k += 5) do_reset(4'(k));
        tally_and_finish();
    end
endmodule // tb_reset_mode_latch_ext_irq
`default_nettype wire
